// ### rtl/bcb_pkg.sv
// package of constants for the bridge control bits block
package bcb_pkg;
  // register byte offsets on apb
  localparam logic [11:0] BRIDGE_CONTROL_OFF = 12'h03c;
  localparam logic [11:0] IRQ_STATUS_OFF     = 12'h040;
  localparam logic [11:0] IRQ_MASK_OFF       = 12'h044;
  localparam logic [11:0] DISPLAY_CTL_OFF    = 12'h048;
  // bridge control field positions
  localparam int FBB_BIT    = 7;
  localparam int SECONDARY_BUS_RESET_CTL_BIT   = 6;
  localparam int MAM_BIT    = 5;
  localparam int LEGACY_DISPLAY_FULL_DECODE_BIT  = 4;
  localparam int VGAEN_BIT  = 3;
  localparam logic [15:0] CTL_WMASK = 16'h00f8;
  localparam logic [15:0] CTL_RESET = 16'h0000;
  // status bit positions
  localparam int ST_UR_SENT   = 0;
  localparam int ST_TA_SENT   = 1;
  localparam int ST_PW_ERR    = 2;
  localparam int ST_DROPPED   = 3;
  localparam int ST_WIDTH     = 4;
  // answer values and legacy display ranges
  localparam logic [31:0] ALL_ONES    = 32'hffffffff;
  localparam logic [9:0]  MONO_LO     = 10'h3b0;
  localparam logic [9:0]  MONO_HI     = 10'h3bb;
  localparam logic [9:0]  COLOR_LO    = 10'h3c0;
  localparam logic [9:0]  COLOR_HI    = 10'h3df;
  localparam logic [5:0]  ALIAS_BASE  = 6'h00;
  // completion status codes toward the upstream link
  localparam logic [2:0]  CPL_SC      = 3'h0;
  localparam logic [2:0]  CPL_UR      = 3'h1;
endpackage

// ### rtl/bcb_bridge_control.sv
// bridge control bits 7..3 with master abort translation and display decode
`timescale 1ns/1ps
module bcb_bridge_control (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // secondary bus side
  output logic             fastBackToBackEnable,
  output logic             downstreamResetOut,
  output logic             secIfInReset,
  // master abort seen on secondary bus
  input  wire logic        secMasterAbort,
  input  wire logic        secAbortIsRead,
  input  wire logic        secAbortIsPosted,
  output logic             upCplValid,
  output logic [2:0]       upCplStatus,
  output logic [31:0]      upCplData,
  output logic             postedWriteError,
  // unsupported request completion from upstream
  input  wire logic        upUrCompletion,
  output logic             secTargetAbort,
  // legacy display decode
  input  wire logic        ioEnable,
  input  wire logic [31:0] ioAddr,
  input  wire logic        ioAddrValid,
  output logic             displayForward,
  // interrupt
  output logic             irq
);

  // all module state in one record
  typedef struct packed {
    logic [15:0]                      ctl;
    logic                             vgaEn;
    logic [bcb_pkg::ST_WIDTH-1:0]     status;
    logic [bcb_pkg::ST_WIDTH-1:0]     mask;
    logic [31:0]                      rdata;
    logic                             ready;
    logic                             slverr;
    logic                             rstOut;
    logic                             cplValid;
    logic [2:0]                       cplStatus;
    logic [31:0]                      cplData;
    logic                             pwErr;
    logic                             targetAbort;
    logic                             fwd;
    logic                             irq;
  } bcb_state_t;

  bcb_state_t stateQ;
  bcb_state_t stateD;

  logic       accessPh;
  logic       wrAcc;
  logic       rdAcc;
  logic [9:0] lowBits;
  logic       lowMatch;
  logic       aliasOk;
  logic       ctlWr;
  logic       abort_report_mode;
  logic [bcb_pkg::ST_WIDTH-1:0] events;

  // apb access and decode helpers
  assign accessPh = psel && penable && !stateQ.ready;
  assign wrAcc    = accessPh && pwrite;
  assign rdAcc    = accessPh && !pwrite;
  assign ctlWr    = wrAcc && (paddr == bcb_pkg::BRIDGE_CONTROL_OFF);
  assign abort_report_mode      = stateQ.ctl[bcb_pkg::MAM_BIT];
  assign lowBits  = ioAddr[9:0];
  assign lowMatch = (lowBits >= bcb_pkg::MONO_LO && lowBits <= bcb_pkg::MONO_HI) ||
                    (lowBits >= bcb_pkg::COLOR_LO && lowBits <= bcb_pkg::COLOR_HI);
  // full decode demands zero alias bits, otherwise any alias matches
  assign aliasOk  = !stateQ.ctl[bcb_pkg::LEGACY_DISPLAY_FULL_DECODE_BIT] || (ioAddr[15:10] == bcb_pkg::ALIAS_BASE);

  // event vector for sticky status
  always_comb
  begin
    events = '0;
    events[bcb_pkg::ST_UR_SENT] = secMasterAbort && secAbortIsRead && !secAbortIsPosted && abort_report_mode;
    events[bcb_pkg::ST_TA_SENT] = upUrCompletion && abort_report_mode;
    events[bcb_pkg::ST_PW_ERR]  = secMasterAbort && secAbortIsPosted && abort_report_mode;
    events[bcb_pkg::ST_DROPPED] = secMasterAbort && !abort_report_mode;
  end

  // next state
  always_comb
  begin
    stateD = stateQ;
    stateD.ready  = accessPh;
    stateD.slverr = 1'b0;
    stateD.rdata  = '0;
    // register writes
    if (wrAcc)
    begin
      unique case (paddr)
        bcb_pkg::BRIDGE_CONTROL_OFF:
          stateD.ctl = (stateQ.ctl & ~bcb_pkg::CTL_WMASK) | (pwdata[15:0] & bcb_pkg::CTL_WMASK);
        bcb_pkg::IRQ_MASK_OFF:
          stateD.mask = pwdata[bcb_pkg::ST_WIDTH-1:0];
        bcb_pkg::DISPLAY_CTL_OFF:
          stateD.vgaEn = pwdata[0];
        bcb_pkg::IRQ_STATUS_OFF:
          stateD.slverr = 1'b0;
        default:
          stateD.slverr = 1'b1;
      endcase
    end
    // register reads, status clears on read
    if (rdAcc)
    begin
      unique case (paddr)
        bcb_pkg::BRIDGE_CONTROL_OFF:
          stateD.rdata = {16'h0000, stateQ.ctl[15:4], stateQ.vgaEn, stateQ.ctl[2:0]};
        bcb_pkg::IRQ_STATUS_OFF:
        begin
          stateD.rdata  = {28'h0000000, stateQ.status};
          stateD.status = '0;
        end
        bcb_pkg::IRQ_MASK_OFF:
          stateD.rdata = {28'h0000000, stateQ.mask};
        bcb_pkg::DISPLAY_CTL_OFF:
          stateD.rdata = {31'h00000000, stateQ.vgaEn};
        default:
          stateD.slverr = 1'b1;
      endcase
    end
    // set wins over clear
    stateD.status = stateD.status | events;
    // reset out follows the control bit
    stateD.rstOut = stateQ.ctl[bcb_pkg::SECONDARY_BUS_RESET_CTL_BIT];
    // master abort translation toward upstream, upstream ur to target abort
    stateD.cplValid  = secMasterAbort && secAbortIsRead && !secAbortIsPosted;
    stateD.cplStatus = abort_report_mode ? bcb_pkg::CPL_UR : bcb_pkg::CPL_SC;
    stateD.cplData   = abort_report_mode ? 32'h00000000 : bcb_pkg::ALL_ONES;
    stateD.pwErr     = secMasterAbort && secAbortIsPosted && abort_report_mode;
    stateD.targetAbort = upUrCompletion && abort_report_mode;
    // legacy display forwarding, qualified by io enable
    stateD.fwd = ioAddrValid && ioEnable && stateQ.vgaEn && (ioAddr[31:16] == 16'h0000) &&
                 lowMatch && aliasOk;
    stateD.irq = |(stateD.status & stateQ.mask);
  end

  // state register
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      stateQ     <= '0;
      stateQ.ctl <= bcb_pkg::CTL_RESET;
    end
    else
    begin
      stateQ <= stateD;
    end
  end

  // outputs straight from flops
  assign prdata               = stateQ.rdata;
  assign pready               = stateQ.ready;
  assign pslverr              = stateQ.slverr;
  assign fastBackToBackEnable = stateQ.ctl[bcb_pkg::FBB_BIT];
  assign downstreamResetOut   = stateQ.rstOut;
  assign secIfInReset         = stateQ.rstOut;
  assign upCplValid           = stateQ.cplValid;
  assign upCplStatus          = stateQ.cplStatus;
  assign upCplData            = stateQ.cplData;
  assign postedWriteError     = stateQ.pwErr;
  assign secTargetAbort       = stateQ.targetAbort;
  assign displayForward       = stateQ.fwd;
  assign irq                  = stateQ.irq;

  // fast back-to-back bit takes the written value at the accepting edge
  chk_fbb_write: assert property (@(posedge clk_sys) disable iff (!resetn)
    ctlWr |=>
    fastBackToBackEnable == $past(pwdata[bcb_pkg::FBB_BIT]))
    else $error("fast back-to-back bit not written");

  // without a control write the bit keeps its value
  chk_fbb_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    !ctlWr |=>
    $stable(fastBackToBackEnable))
    else $error("fast back-to-back bit changed alone");

  // secondary reset bit takes the written value
  chk_secondary_bus_reset_ctl_write: assert property (@(posedge clk_sys) disable iff (!resetn)
    ctlWr |=>
    stateQ.ctl[bcb_pkg::SECONDARY_BUS_RESET_CTL_BIT] == $past(pwdata[bcb_pkg::SECONDARY_BUS_RESET_CTL_BIT]))
    else $error("secondary reset bit not written");

  // reset out one cycle after the bit rises
  chk_rst_out: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(stateQ.ctl[bcb_pkg::SECONDARY_BUS_RESET_CTL_BIT]) |=>
    downstreamResetOut)
    else $error("reset out late");

  // reset out is the bit delayed by one register
  chk_rst_follow: assert property (@(posedge clk_sys) disable iff (!resetn)
    downstreamResetOut ==
    $past(stateQ.ctl[bcb_pkg::SECONDARY_BUS_RESET_CTL_BIT]))
    else $error("reset out does not follow bit");

  // interface stays in reset while the bit stands
  chk_rst_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    stateQ.ctl[bcb_pkg::SECONDARY_BUS_RESET_CTL_BIT] [*2] |->
    secIfInReset)
    else $error("reset not held");

  // interface leaves reset once the bit clears
  chk_rst_fall: assert property (@(posedge clk_sys) disable iff (!resetn)
    $fell(stateQ.ctl[bcb_pkg::SECONDARY_BUS_RESET_CTL_BIT]) |=>
    !secIfInReset)
    else $error("reset not released");

  // unreported read abort completes with all ones
  chk_read_ones: assert property (@(posedge clk_sys) disable iff (!resetn)
    (secMasterAbort && secAbortIsRead && !secAbortIsPosted && !abort_report_mode) |=>
    (upCplValid && upCplData == bcb_pkg::ALL_ONES && upCplStatus == bcb_pkg::CPL_SC))
    else $error("no all ones");

  // unreported posted abort is dropped without completion or posted error
  chk_write_drop: assert property (@(posedge clk_sys) disable iff (!resetn)
    (secMasterAbort && secAbortIsPosted && !abort_report_mode) |=>
    (!upCplValid && !postedWriteError))
    else $error("dropped write reported");

  // unreported abort leaves a dropped mark
  chk_drop_status: assert property (@(posedge clk_sys) disable iff (!resetn)
    (secMasterAbort && !abort_report_mode) |=>
    stateQ.status[bcb_pkg::ST_DROPPED])
    else $error("drop not recorded");

  // abort mode bit takes the written value
  chk_mam_write: assert property (@(posedge clk_sys) disable iff (!resetn)
    ctlWr |=>
    abort_report_mode == $past(pwdata[bcb_pkg::MAM_BIT]))
    else $error("abort mode bit not written");

  // reported read abort completes with unsupported request
  chk_ur_sent: assert property (@(posedge clk_sys) disable iff (!resetn)
    (secMasterAbort && secAbortIsRead && !secAbortIsPosted && abort_report_mode) |=>
    (upCplValid && upCplStatus == bcb_pkg::CPL_UR))
    else $error("no ur status");

  // unsupported request completion is recorded
  chk_ur_status: assert property (@(posedge clk_sys) disable iff (!resetn)
    (secMasterAbort && secAbortIsRead && !secAbortIsPosted && abort_report_mode) |=>
    stateQ.status[bcb_pkg::ST_UR_SENT])
    else $error("ur not recorded");

  // completions only answer non-posted read aborts
  chk_cpl_source: assert property (@(posedge clk_sys) disable iff (!resetn)
    upCplValid |->
    ($past(secMasterAbort) && $past(secAbortIsRead) && !$past(secAbortIsPosted)))
    else $error("completion without abort");

  // reported upstream ur becomes a target abort
  chk_ta_sent: assert property (@(posedge clk_sys) disable iff (!resetn)
    (upUrCompletion && abort_report_mode) |=>
    secTargetAbort)
    else $error("no target abort");

  // target abort only for a reported upstream ur
  chk_ta_source: assert property (@(posedge clk_sys) disable iff (!resetn)
    secTargetAbort |->
    ($past(upUrCompletion) && $past(abort_report_mode)))
    else $error("target abort without cause");

  // target abort is recorded
  chk_ta_status: assert property (@(posedge clk_sys) disable iff (!resetn)
    (upUrCompletion && abort_report_mode) |=>
    stateQ.status[bcb_pkg::ST_TA_SENT])
    else $error("target abort not recorded");

  // posted error only for a reported posted abort
  chk_pw_error: assert property (@(posedge clk_sys) disable iff (!resetn)
    postedWriteError |->
    ($past(abort_report_mode) && $past(secMasterAbort) && $past(secAbortIsPosted)))
    else $error("bad posted error");

  // reported posted abort raises the error and its mark
  chk_pw_raise: assert property (@(posedge clk_sys) disable iff (!resetn)
    (secMasterAbort && secAbortIsPosted && abort_report_mode) |=>
    (postedWriteError && stateQ.status[bcb_pkg::ST_PW_ERR]))
    else $error("posted error missing");

  // no posted error while aborts are unreported
  chk_pw_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
    (secMasterAbort && !abort_report_mode) |=>
    !postedWriteError)
    else $error("posted error in quiet mode");

  // full decode bit takes the written value
  chk_legacy_display_full_decode_write: assert property (@(posedge clk_sys) disable iff (!resetn)
    ctlWr |=>
    stateQ.ctl[bcb_pkg::LEGACY_DISPLAY_FULL_DECODE_BIT] == $past(pwdata[bcb_pkg::LEGACY_DISPLAY_FULL_DECODE_BIT]))
    else $error("full decode bit not written");

  // full decode refuses aliases
  chk_alias_decode: assert property (@(posedge clk_sys) disable iff (!resetn)
    displayForward |->
    ($past(ioAddr[15:10]) == bcb_pkg::ALIAS_BASE || !$past(stateQ.ctl[bcb_pkg::LEGACY_DISPLAY_FULL_DECODE_BIT])))
    else $error("alias forwarded");

  // partial decode forwards an alias
  chk_alias_pass: assert property (@(posedge clk_sys) disable iff (!resetn)
    (ioAddrValid && ioEnable && stateQ.vgaEn && !stateQ.ctl[bcb_pkg::LEGACY_DISPLAY_FULL_DECODE_BIT] &&
     ioAddr[31:16] == 16'h0000 && ioAddr[9:0] == bcb_pkg::COLOR_LO) |=>
    displayForward)
    else $error("alias not forwarded");

  // forwarding needs display and io enable
  chk_vga_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
    displayForward |->
    ($past(stateQ.vgaEn) && $past(ioEnable)))
    else $error("forward without enable");

  // full decode bit alone never forwards
  chk_full_inert: assert property (@(posedge clk_sys) disable iff (!resetn)
    !stateQ.vgaEn |=>
    !displayForward)
    else $error("forward with display off");

  // forwarded addresses lie in the legacy ranges
  chk_fwd_range: assert property (@(posedge clk_sys) disable iff (!resetn)
    displayForward |->
    ($past(ioAddrValid) && $past(ioAddr[31:16]) == 16'h0000 &&
     (($past(ioAddr[9:0]) >= bcb_pkg::MONO_LO && $past(ioAddr[9:0]) <= bcb_pkg::MONO_HI) ||
      ($past(ioAddr[9:0]) >= bcb_pkg::COLOR_LO && $past(ioAddr[9:0]) <= bcb_pkg::COLOR_HI))))
    else $error("forward outside ranges");

  // a plain legacy address is forwarded
  chk_fwd_base: assert property (@(posedge clk_sys) disable iff (!resetn)
    (ioAddrValid && ioEnable && stateQ.vgaEn && ioAddr[31:10] == 22'h000000 &&
     ioAddr[9:0] == bcb_pkg::MONO_LO) |=>
    displayForward)
    else $error("legacy address not forwarded");

endmodule

// ### tb/bcb_sec_bus_model.sv
// secondary bus model that raises master aborts toward the bridge
`timescale 1ns/1ps
module bcb_sec_bus_model (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic resetn,
  // downstream reset from the bridge
  input  wire logic downstreamResetOut,
  // abort signalling
  output logic      secMasterAbort,
  output logic      secAbortIsRead,
  output logic      secAbortIsPosted
);
  // one abort pulse; devices held in reset stay silent; qualifiers scramble after
  task automatic abort(input logic rd, input logic po);
    secMasterAbort   <= !downstreamResetOut;
    secAbortIsRead   <= rd;
    secAbortIsPosted <= po;
    @(posedge clk_sys);
    secMasterAbort   <= 1'b0;
    secAbortIsRead   <= ~rd;
    secAbortIsPosted <= ~po;
  endtask
  // idle lines at time zero
  initial
  begin
    secMasterAbort   = 1'b0;
    secAbortIsRead   = 1'b0;
    secAbortIsPosted = 1'b0;
  end
endmodule

// ### tb/bcb_bridge_control_tb.sv
// self-checking bench for the bridge control bits block
`timescale 1ns/1ps
module bcb_bridge_control_tb;
  localparam logic [11:0] CTL = bcb_pkg::BRIDGE_CONTROL_OFF;
  localparam logic [11:0] STA = bcb_pkg::IRQ_STATUS_OFF;
  localparam logic [11:0] MSK = bcb_pkg::IRQ_MASK_OFF;
  localparam logic [31:0] ADR [8] = '{32'h3af, 32'h3b0, 32'h3bb, 32'h3bc, 32'h3c0, 32'h3df, 32'h7c0, 32'h103c0};
  logic        clk_sys = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        upUrCompletion = 1'b0, ioEnable = 1'b0, ioAddrValid = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, ioAddr = 32'h0, rd, prdata, upCplData;
  logic [2:0]  upCplStatus;
  logic        pready, pslverr, fastBackToBackEnable, downstreamResetOut, secIfInReset, irq;
  logic        secMasterAbort, secAbortIsRead, secAbortIsPosted, upCplValid, postedWriteError;
  logic        secTargetAbort, displayForward;
  logic [15:0] ctl;
  int          bad_count = 0, num_checks = 0, cyc = 0, seed = 21;
  bcb_bridge_control dut (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .fastBackToBackEnable, .downstreamResetOut, .secIfInReset, .secMasterAbort, .secAbortIsRead,
    .secAbortIsPosted, .upCplValid, .upCplStatus, .upCplData, .postedWriteError, .upUrCompletion,
    .secTargetAbort, .ioEnable, .ioAddr, .ioAddrValid, .displayForward, .irq);
  bcb_sec_bus_model sbm (.clk_sys, .resetn, .downstreamResetOut, .secMasterAbort, .secAbortIsRead,
    .secAbortIsPosted);
  // clock and hang guard
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      finish_test();
    end
  end
  // verdict
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // compare one value
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // apb transfer; read data taken in the cycle pready stands
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one-cycle pulse on an event input, outputs settled afterwards
  task automatic pulse(input logic [31:0] a, input logic ur);
    @(posedge clk_sys);
    ioAddr <= a;
    ioAddrValid <= !ur;
    upUrCompletion <= ur;
    @(posedge clk_sys);
    ioAddrValid <= 1'b0;
    upUrCompletion <= 1'b0;
    ioAddr <= ~a;
    #1;
  endtask
  // expected display forwarding decision
  function automatic logic fwdExp(logic [31:0] a, logic en, logic full, logic io);
    logic [9:0] lo;
    lo = a[9:0];
    return io && en && a[31:16] == 16'h0 && (!full || a[15:10] == 6'h00) &&
      ((lo >= 10'h3b0 && lo <= 10'h3bb) || (lo >= 10'h3c0 && lo <= 10'h3df));
  endfunction
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk_sys);
    chk("outs in reset", 32'h0, {downstreamResetOut, fastBackToBackEnable, irq});
    resetn <= 1'b1;
    apb(1'b0, CTL, 32'h0);
    chk("ctl reset", 32'h0, rd);
    for (int i = 0; i < 10; i++)
    begin
      ctl = (i < 2) ? {16{i[0]}} : 16'($random(seed));
      apb(1'b1, CTL, {16'hffff, ctl});
      apb(1'b0, CTL, 32'h0);
      chk("ctl", {24'h0, ctl[7:4], 4'h0}, rd);
      chk("fbb", ctl[7], fastBackToBackEnable);
      chk("sec reset", {ctl[6], ctl[6]}, {downstreamResetOut, secIfInReset});
    end
    for (int m = 0; m < 2; m++)
    begin
      apb(1'b1, CTL, m ? 32'h20 : 32'h0);
      for (int k = 0; k < 3; k++)
      begin
        @(posedge clk_sys);
        sbm.abort(k == 0, k == 1);
        #1;
        chk("cpl valid", k == 0, upCplValid);
        chk("pw error", m == 1 && k == 1, postedWriteError);
        if (k == 0)
        begin
          chk("cpl status", m ? bcb_pkg::CPL_UR : bcb_pkg::CPL_SC, upCplStatus);
          chk("cpl data", m ? 32'h0 : bcb_pkg::ALL_ONES, upCplData);
        end
      end
      pulse(32'h0, 1'b1);
      chk("target abort", m, secTargetAbort);
    end
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, bcb_pkg::DISPLAY_CTL_OFF, i[0]);
      apb(1'b1, CTL, {27'h0, i[2], 4'h0});
      apb(1'b0, CTL, 32'h0);
      chk("ctl display", {27'h0, i[2], i[0], 3'h0}, rd);
      ioEnable <= i[1];
      for (int j = 0; j < 9; j++)
      begin
        ctl = 16'($random(seed));
        pulse(j < 8 ? ADR[j] : {15'h0, ctl[15], ctl[15:6], ctl[0] ? 6'h00 : 6'h05}, 1'b0);
        chk("forward", fwdExp(~ioAddr, i[0], i[2], i[1]), displayForward);
      end
    end
    apb(1'b0, STA, 32'h0);
    apb(1'b0, STA, 32'h0);
    chk("status cleared", 32'h0, rd);
    apb(1'b1, MSK, 32'h0);
    apb(1'b1, CTL, 32'h20);
    @(posedge clk_sys);
    sbm.abort(1'b0, 1'b1);
    repeat (2) @(posedge clk_sys);
    #1 chk("irq masked", 32'h0, irq);
    apb(1'b1, MSK, 32'h4);
    apb(1'b0, MSK, 32'h0);
    chk("mask", 32'h4, rd);
    chk("irq", 32'h1, irq);
    apb(1'b0, STA, 32'h0);
    chk("status", 32'h4, rd);
    repeat (2) @(posedge clk_sys);
    #1 chk("irq cleared", 32'h0, irq);
    apb(1'b0, 12'hffc, 32'h0);
    chk("unmapped", 32'h1, err);
    finish_test();
  end
endmodule
